/* shared/cisp_consts.vh */
// Functional notes
// - Idle select write gates CPU clock only after the writing instruction completes.
// - Idle keeps all contents and keeps timer, interrupt and peripheral clocks running.
// - Idle ends on any enabled interrupt request or the external reset pin.
// - Interrupt wake clears idle select, restarts CPU clock, services the interrupt.
// - After interrupt return, execution continues after the idle-requesting instruction.
// - Reset ending idle runs the normal reset sequence, fetching from address zero.
// - Enabled watchdog keeps counting in idle and resets to end it.
// - Stop select write halts CPU and oscillators after the instruction completes.
// - Stop ends only by reset, then reset sequence fetching from address zero.
// - In stop only the enabled missing clock detector runs and may reset.
// - Idle and stop select bits read zero; power control resets to zero.
`ifndef CISP_CONSTS_VH
`define CISP_CONSTS_VH

`define CISP_PWR_CTL_ADDR     8'h87
`define CISP_PWR_CTL_RESET    8'h00
`define CISP_IDLE_BIT         0
`define CISP_STOP_BIT         1
`define CISP_RESET_VECTOR     17'h0_0000
`define CISP_CLK_MHZ          20
`define CISP_CLKMON_TIMEOUT_US 100
`define CISP_CLKMON_CYCLES    (`CISP_CLKMON_TIMEOUT_US * `CISP_CLK_MHZ)
`define CISP_WDOG_CYCLES      1024
`define CISP_RST_SEQ_CYCLES   3'h4

`endif

/* verilog/cisp_wdog.v */
`timescale 1ns/1ps
`default_nettype none
`include "cisp_consts.vh"

module cisp_wdog (
  input  wire       i_clock,
  input  wire       i_rst_n,
  input  wire       i_enable,
  input  wire       i_run,
  input  wire       i_kick,
  input  wire       i_clear,
  output reg        o_expire
);

  localparam integer LAST_I = `CISP_WDOG_CYCLES - 1;
  localparam [15:0]  LAST   = LAST_I[15:0];

  reg [15:0] cnt_reg;

  // Keeps counting whenever enabled, not kicked or cleared, and i_run is high, idle included
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg  <= 16'h0000;
      o_expire <= 1'b0;
    end else begin
      o_expire <= 1'b0;
      if (i_clear || i_kick || !i_enable) begin
        cnt_reg <= 16'h0000;
      end else if (i_run) begin
        if (cnt_reg == LAST) begin
          cnt_reg  <= 16'h0000;
          o_expire <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 16'h0001;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* verilog/cisp_mcd.v */
`timescale 1ns/1ps
`default_nettype none
`include "cisp_consts.vh"

module cisp_clkmon (
  input  wire       i_clock,
  input  wire       i_rst_n,
  input  wire       i_enable,
  input  wire       i_osc_run,
  input  wire       i_clear,
  output reg        o_expire
);

  localparam integer LAST_I = `CISP_CLKMON_CYCLES - 1;
  localparam [11:0]  LAST   = LAST_I[11:0];

  reg [11:0] cnt_reg;

  // Times how long the oscillator has been absent; its own timebase
  // is modelled by the system clock input
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg  <= 12'h000;
      o_expire <= 1'b0;
    end else begin
      o_expire <= 1'b0;
      if (i_clear || i_osc_run || !i_enable) begin
        cnt_reg <= 12'h000;
      end else if (cnt_reg == LAST) begin
        cnt_reg  <= 12'h000;
        o_expire <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 12'h001;
      end
    end
  end

endmodule
`default_nettype wire

/* verilog/cisp_power_ctl.v */
`timescale 1ns/1ps
`default_nettype none
`include "cisp_consts.vh"

module cisp_power_ctl (
  input  wire        i_clock,
  input  wire        i_rst_n,
  input  wire        i_rst_pin_n,
  input  wire        i_sfr_wr,
  input  wire        i_sfr_rd,
  input  wire [7:0]  i_sfr_addr,
  input  wire [7:0]  i_sfr_wdata,
  input  wire        i_instr_done,
  input  wire        i_int_pending,
  input  wire        i_irq_return,
  input  wire        i_wdog_enable,
  input  wire        i_wdog_kick,
  input  wire        i_clkmon_enable,
  output reg  [7:0]  o_sfr_rdata,
  output reg         o_sfr_rd_valid,
  output reg         o_cpu_clk_en,
  output reg         o_periph_clk_en,
  output reg         o_osc_en,
  output reg         o_core_rst,
  output reg         o_fetch_restart,
  output reg  [16:0] o_fetch_addr,
  output reg         o_int_wake,
  output reg         o_isr_from_idle,
  output reg         o_idle,
  output reg         o_stop,
  output reg  [2:0]  o_reset_cause
);

  localparam [5:0] ST_RUN       = 6'b00_0001;
  localparam [5:0] ST_IDLE_PEND = 6'b00_0010;
  localparam [5:0] ST_STOP_PEND = 6'b00_0100;
  localparam [5:0] ST_IDLE      = 6'b00_1000;
  localparam [5:0] ST_STOP      = 6'b01_0000;
  localparam [5:0] ST_RESET     = 6'b10_0000;

  localparam [7:0] CTL_RESET = `CISP_PWR_CTL_RESET;

  function is_pwr_ctl;
    input [7:0] addr;
    begin
      is_pwr_ctl = (addr == `CISP_PWR_CTL_ADDR);
    end
  endfunction

  reg  [5:0] state_reg;
  reg  [5:0] state_next;
  reg  [5:0] ctl_hi_reg;
  reg  [5:0] ctl_hi_next;
  reg  [2:0] seq_cnt_reg;
  reg  [2:0] seq_cnt_next;
  reg        wake_next;
  reg        restart_next;
  reg        from_idle_next;
  reg  [2:0] cause_next;

  wire       wdog_expire;
  wire       clkmon_expire;
  wire       pin_rst;
  wire       rst_req;
  wire       ctl_wr;
  wire       wr_idle;
  wire       wr_stop;
  wire       in_stop;
  wire       in_reset;

  assign pin_rst  = ~i_rst_pin_n;
  assign rst_req  = pin_rst | wdog_expire | clkmon_expire;
  assign ctl_wr   = i_sfr_wr & is_pwr_ctl(i_sfr_addr);
  assign wr_idle  = ctl_wr & i_sfr_wdata[`CISP_IDLE_BIT];
  assign wr_stop  = ctl_wr & i_sfr_wdata[`CISP_STOP_BIT];
  assign in_stop  = state_reg[4];
  assign in_reset = state_reg[5];

  // Counting continues in idle; stop holds the count and reset clears it
  cisp_wdog u_wdog (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_enable (i_wdog_enable),
    .i_run    (~in_stop),
    .i_kick   (i_wdog_kick & o_cpu_clk_en),
    .i_clear  (in_reset),
    .o_expire (wdog_expire)
  );

  // The only watcher left alive in stop
  cisp_clkmon u_clkmon (
    .i_clock   (i_clock),
    .i_rst_n   (i_rst_n),
    .i_enable  (i_clkmon_enable),
    .i_osc_run (o_osc_en),
    .i_clear   (in_reset),
    .o_expire  (clkmon_expire)
  );

  always @* begin
    state_next     = state_reg;
    ctl_hi_next    = ctl_hi_reg;
    seq_cnt_next   = seq_cnt_reg;
    wake_next      = 1'b0;
    restart_next   = 1'b0;
    from_idle_next = o_isr_from_idle;
    cause_next     = o_reset_cause;
    if (i_irq_return) begin
      from_idle_next = 1'b0;
    end
    if (rst_req) begin
      // Any reset source, from any state, restarts the sequence
      state_next     = ST_RESET;
      seq_cnt_next   = `CISP_RST_SEQ_CYCLES;
      ctl_hi_next    = CTL_RESET[7:2];
      from_idle_next = 1'b0;
      cause_next     = {clkmon_expire, wdog_expire, pin_rst};
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (ctl_wr) begin
            ctl_hi_next = i_sfr_wdata[7:2];
          end
          if (wr_stop) begin
            state_next = ST_STOP_PEND;
          end else if (wr_idle) begin
            state_next = ST_IDLE_PEND;
          end
          if ((wr_stop || wr_idle) && i_instr_done) begin
            state_next = wr_stop ? ST_STOP : ST_IDLE;
          end
        end
        ST_IDLE_PEND: begin
          if (i_instr_done) begin
            state_next = ST_IDLE;
          end
        end
        ST_STOP_PEND: begin
          if (i_instr_done) begin
            state_next = ST_STOP;
          end
        end
        ST_IDLE: begin
          if (i_int_pending) begin
            // Idle select is implicitly cleared by leaving the state
            state_next     = ST_RUN;
            wake_next      = 1'b1;
            from_idle_next = 1'b1;
          end
        end
        ST_STOP: begin
          state_next = ST_STOP;
        end
        ST_RESET: begin
          if (seq_cnt_reg == 3'h0) begin
            state_next   = ST_RUN;
            restart_next = 1'b1;
          end else begin
            seq_cnt_next = seq_cnt_reg - 3'h1;
          end
        end
        default: begin
          state_next   = ST_RESET;
          seq_cnt_next = `CISP_RST_SEQ_CYCLES;
        end
      endcase
    end
  end

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg   <= ST_RESET;
      ctl_hi_reg  <= CTL_RESET[7:2];
      seq_cnt_reg <= `CISP_RST_SEQ_CYCLES;
    end else begin
      state_reg   <= state_next;
      ctl_hi_reg  <= ctl_hi_next;
      seq_cnt_reg <= seq_cnt_next;
    end
  end

  // Clock gating and status outputs follow the next state
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cpu_clk_en    <= 1'b1;
      o_periph_clk_en <= 1'b1;
      o_osc_en        <= 1'b1;
      o_core_rst      <= 1'b1;
      o_fetch_restart <= 1'b0;
      o_fetch_addr    <= `CISP_RESET_VECTOR;
      o_int_wake      <= 1'b0;
      o_isr_from_idle <= 1'b0;
      o_idle          <= 1'b0;
      o_stop          <= 1'b0;
      o_reset_cause   <= 3'h0;
    end else begin
      o_cpu_clk_en    <= ~(state_next[3] | state_next[4]);
      o_periph_clk_en <= ~state_next[4];
      o_osc_en        <= ~state_next[4];
      o_core_rst      <= state_next[5];
      o_fetch_restart <= restart_next;
      o_fetch_addr    <= `CISP_RESET_VECTOR;
      o_int_wake      <= wake_next;
      o_isr_from_idle <= from_idle_next;
      o_idle          <= state_next[3];
      o_stop          <= state_next[4];
      o_reset_cause   <= cause_next;
    end
  end

  // Select bits are write-only triggers and always read back as zero
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sfr_rdata    <= CTL_RESET;
      o_sfr_rd_valid <= 1'b0;
    end else begin
      o_sfr_rd_valid <= i_sfr_rd & is_pwr_ctl(i_sfr_addr);
      if (i_sfr_rd && is_pwr_ctl(i_sfr_addr)) begin
        o_sfr_rdata <= {ctl_hi_reg, 2'b00};
      end else begin
        o_sfr_rdata <= 8'h00;
      end
    end
  end

endmodule
`default_nettype wire

/* sim/cisp_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cisp_cpu_model (
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_sfr_wr,
  input  wire logic i_cpu_clk_en,
  output var  logic o_instr_done
);
  // Register write completes one cycle later; its successor is multi-byte
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_instr_done <= 1'b0;
    end else begin
      o_instr_done <= i_sfr_wr && i_cpu_clk_en;
    end
  end
endmodule
`default_nettype wire

/* sim/cisp_power_ctl_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module cisp_power_ctl_chk (
  input wire logic        i_clock,
  input wire logic        i_rst_n,
  input wire logic        i_rst_pin_n,
  input wire logic        i_sfr_wr,
  input wire logic [7:0]  i_sfr_addr,
  input wire logic [7:0]  i_sfr_wdata,
  input wire logic        i_instr_done,
  input wire logic        i_int_pending,
  input wire logic        i_irq_return,
  input wire logic        o_cpu_clk_en,
  input wire logic        o_periph_clk_en,
  input wire logic        o_osc_en,
  input wire logic        o_core_rst,
  input wire logic        o_fetch_restart,
  input wire logic [16:0] o_fetch_addr,
  input wire logic        o_int_wake,
  input wire logic        o_isr_from_idle,
  input wire logic        o_idle,
  input wire logic        o_stop
);
  wire run;
  wire hit;
  assign run = o_cpu_clk_en && !o_core_rst && !o_idle && !o_stop;
  assign hit = run && i_sfr_wr && i_sfr_addr == 8'h87;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  property p_idle_in;
    hit && i_sfr_wdata[1:0] == 2'h1 ##1 i_instr_done && !i_int_pending
      && i_rst_pin_n |=> o_idle && !o_cpu_clk_en;
  endproperty
  a_idle_in: assert property (p_idle_in)
    else $error("idle not entered after write");
  property p_keep; o_idle |-> o_periph_clk_en && o_osc_en; endproperty
  a_keep: assert property (p_keep)
    else $error("clocks stopped in idle");
  property p_wake;
    o_idle && i_int_pending && i_rst_pin_n |=> !o_idle && o_cpu_clk_en
      && o_int_wake;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake on interrupt");
  property p_isr;
    o_isr_from_idle && i_irq_return |=> !o_isr_from_idle;
  endproperty
  a_isr: assert property (p_isr)
    else $error("idle service flag kept after return");
  property p_pin; !i_rst_pin_n |=> o_core_rst && !o_idle && !o_stop; endproperty
  a_pin: assert property (p_pin)
    else $error("pin reset ignored");
  property p_fetch;
    $fell(o_core_rst) |-> o_fetch_restart && o_fetch_addr == 17'h0_0000;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("bad restart fetch");
  property p_stop;
    o_stop |-> !o_osc_en && !o_periph_clk_en && !o_cpu_clk_en && !o_int_wake;
  endproperty
  a_stop: assert property (p_stop)
    else $error("activity in stop");
  property p_both;
    hit && i_sfr_wdata[1:0] == 2'h3 ##1 i_instr_done && i_rst_pin_n |=> o_stop;
  endproperty
  a_both: assert property (p_both)
    else $error("double select did not stop");
  c_wake: cover property (o_int_wake);
  c_stop_rst: cover property (o_stop ##1 o_core_rst);
  c_restart: cover property (o_fetch_restart);
endmodule
bind cisp_power_ctl cisp_power_ctl_chk cisp_power_ctl_chk_inst (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_rst_pin_n(i_rst_pin_n),
  .i_sfr_wr(i_sfr_wr), .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
  .i_instr_done(i_instr_done), .i_int_pending(i_int_pending),
  .i_irq_return(i_irq_return),
  .o_cpu_clk_en(o_cpu_clk_en), .o_periph_clk_en(o_periph_clk_en),
  .o_osc_en(o_osc_en), .o_core_rst(o_core_rst),
  .o_fetch_restart(o_fetch_restart), .o_fetch_addr(o_fetch_addr),
  .o_int_wake(o_int_wake), .o_isr_from_idle(o_isr_from_idle),
  .o_idle(o_idle), .o_stop(o_stop));
`default_nettype wire

/* sim/tb_cisp_power_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cisp_consts.vh"
module tb_cisp_power_ctl;
  logic        i_clock = 1'b0, i_rst_n = 1'b0, i_rst_pin_n = 1'b1;
  logic        i_sfr_wr = 1'b0, i_sfr_rd = 1'b0, i_irq_return = 1'b0;
  logic        i_int_pending = 1'b0, i_wdog_enable = 1'b0;
  logic        i_clkmon_enable = 1'b0;
  logic [7:0]  i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00;
  wire logic   i_instr_done, o_rd_v, o_cpu, o_per, o_osc, o_rst, o_fr;
  wire logic   o_wake, o_isr, o_idle, o_stop;
  wire logic [7:0]  o_rdata;
  wire logic [16:0] o_faddr;
  wire logic [2:0]  o_cause;
  int          num_errors = 0, compares = 0, n;
  cisp_power_ctl cisp_power_ctl_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_rst_pin_n(i_rst_pin_n), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
    .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
    .i_instr_done(i_instr_done), .i_int_pending(i_int_pending),
    .i_irq_return(i_irq_return), .i_wdog_enable(i_wdog_enable),
    .i_wdog_kick(1'b0),
    .i_clkmon_enable(i_clkmon_enable), .o_sfr_rdata(o_rdata),
    .o_sfr_rd_valid(o_rd_v),
    .o_cpu_clk_en(o_cpu), .o_periph_clk_en(o_per), .o_osc_en(o_osc),
    .o_core_rst(o_rst), .o_fetch_restart(o_fr), .o_fetch_addr(o_faddr),
    .o_int_wake(o_wake), .o_isr_from_idle(o_isr), .o_idle(o_idle),
    .o_stop(o_stop), .o_reset_cause(o_cause));
  cisp_cpu_model cisp_cpu_model_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_sfr_wr(i_sfr_wr), .i_cpu_clk_en(o_cpu), .o_instr_done(i_instr_done));
  always #25 i_clock = ~i_clock;
  task automatic chk(string what, logic [16:0] exp, logic [16:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(negedge i_clock);
  endtask
  task automatic wr(logic [7:0] d);
    i_sfr_addr = `CISP_PWR_CTL_ADDR;
    i_sfr_wdata = d;
    i_sfr_wr = 1'b1;
    cyc(1);
    i_sfr_wr = 1'b0;
    cyc(2);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    i_sfr_addr = a;
    i_sfr_rd = 1'b1;
    cyc(1);
    i_sfr_rd = 1'b0;
    chk("read data", exp, o_rdata);
    chk("read valid", a == `CISP_PWR_CTL_ADDR, o_rd_v);
  endtask
  task automatic boot(int lim, logic [2:0] cause);
    n = 0;
    while (o_fr !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
    chk("restart", 1'b1, o_fr);
    chk("fetch addr", `CISP_RESET_VECTOR, o_faddr);
    chk("reset cause", cause, o_cause);
    chk("core reset", 1'b0, o_rst);
  endtask
  task automatic t_regs();
    wr(8'hfc);
    chk("mode", 2'b00, {o_idle, o_stop});
    rd(`CISP_PWR_CTL_ADDR, 8'hfc);
    rd(8'h86, 8'h00);
    $display("regs done");
  endtask
  task automatic t_idle();
    wr(8'hfd);
    chk("idle clocks", 4'b1011, {o_idle, o_cpu, o_per, o_osc});
    rd(`CISP_PWR_CTL_ADDR, 8'hfc);
    i_int_pending = 1'b1;
    cyc(1);
    chk("wake", 4'b0111, {o_idle, o_cpu, o_wake, o_isr});
    i_int_pending = 1'b0;
    cyc(1);
    chk("wake pulse", 1'b0, o_wake);
    i_irq_return = 1'b1;
    cyc(1);
    i_irq_return = 1'b0;
    chk("isr flag", 1'b0, o_isr);
    $display("idle done");
  endtask
  task automatic t_wdog();
    i_wdog_enable = 1'b1;
    wr(8'h01);
    chk("idle", 1'b1, o_idle);
    boot(1200, 3'h2);
    i_wdog_enable = 1'b0;
    chk("idle after reset", 1'b0, o_idle);
    rd(`CISP_PWR_CTL_ADDR, 8'h00);
    $display("watchdog done");
  endtask
  task automatic t_stop();
    wr(8'h03);
    chk("stop", 4'b1000, {o_stop, o_osc, o_per, o_cpu});
    i_int_pending = 1'b1;
    cyc(3);
    chk("stop vs int", 2'b10, {o_stop, o_wake});
    i_int_pending = 1'b0;
    i_rst_pin_n = 1'b0;
    cyc(1);
    chk("pin reset", 1'b1, o_rst);
    i_rst_pin_n = 1'b1;
    boot(20, 3'h1);
    $display("stop done");
  endtask
  task automatic t_clkmon();
    i_clkmon_enable = 1'b1;
    wr(8'h02);
    chk("stop", 1'b1, o_stop);
    boot(2100, 3'h4);
    chk("detector span", 1'b1, n >= 1995 && n <= 2015);
    i_clkmon_enable = 1'b0;
    $display("detector done");
  endtask
  task automatic complete_run();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    cyc(8);
    i_rst_n = 1'b1;
    boot(20, 3'h0);
    rd(`CISP_PWR_CTL_ADDR, `CISP_PWR_CTL_RESET);
    t_regs();
    t_idle();
    t_wdog();
    t_stop();
    t_clkmon();
    complete_run();
  end
  initial begin
    #1_000_000;
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
